// ===== design/aptlb_map.vh
// register offsets, field positions and reset values for the aperture tlb
`ifndef APTLB_MAP_VH
`define APTLB_MAP_VH
`define APTLB_CTRL_OFFSET    8'hb0
`define APTLB_CTRL_RESET     32'h00000000
`define APTLB_EN_BIT         7
`define APTLB_OVR_BIT        0
`define APTLB_RATE_FORCED    3'h1
`define APTLB_WIDTH_LOW      8
`endif

// ===== design/aptlb_cache.v
// aperture translation cache: tags, entries, valid bits and lru order
`timescale 1ns/1ps
module aptlb_cache #(
    parameter ENTRIES = 8,
    parameter IDX_W   = 3,
    parameter TAG_W   = 20,
    parameter DATA_W  = 32
) (
    input  wire              ref_clk_i,
    input  wire              sys_rst_i,
    input  wire              flush_i,
    input  wire [TAG_W-1:0]  look_tag_i,
    output reg               hit_o,
    output reg  [DATA_W-1:0] hit_data_o,
    input  wire              touch_i,
    input  wire              fill_i,
    input  wire [TAG_W-1:0]  fill_tag_i,
    input  wire [DATA_W-1:0] fill_data_i,
    input  wire              fill_valid_i
);
    reg [TAG_W-1:0]  tag_r   [0:ENTRIES-1];
    reg [DATA_W-1:0] data_r  [0:ENTRIES-1];
    reg              valid_r [0:ENTRIES-1];
    reg              evalid_r[0:ENTRIES-1];
    reg [IDX_W-1:0]  age_r   [0:ENTRIES-1];
    reg [IDX_W-1:0]  hit_idx;
    reg [IDX_W-1:0]  lru_idx;
    reg [IDX_W-1:0]  use_idx;
    integer          i;
    integer          j;

    always @* begin
        hit_o      = 1'b0;
        hit_data_o = {DATA_W{1'b0}};
        hit_idx    = {IDX_W{1'b0}};
        lru_idx    = {IDX_W{1'b0}};
        for (i = 0; i < ENTRIES; i = i + 1) begin
            // invalid-marked entries still hit so they are not refetched
            if (valid_r[i] && tag_r[i] == look_tag_i) begin
                hit_o      = 1'b1;
                hit_data_o = data_r[i];
                hit_idx    = i[IDX_W-1:0];
            end
            if (age_r[i] == {IDX_W{1'b1}})
                lru_idx = i[IDX_W-1:0];
        end
        use_idx = fill_i ? lru_idx : hit_idx;
    end

    always @(posedge ref_clk_i) begin
        for (j = 0; j < ENTRIES; j = j + 1) begin
            if (sys_rst_i) begin
                valid_r[j]  <= 1'b0;
                evalid_r[j] <= 1'b0;
                tag_r[j]    <= {TAG_W{1'b0}};
                data_r[j]   <= {DATA_W{1'b0}};
                age_r[j]    <= j[IDX_W-1:0];
            end else begin
                if (flush_i && !fill_i)
                    valid_r[j] <= 1'b0;
                if ((touch_i || fill_i) && age_r[j] < age_r[use_idx])
                    age_r[j] <= age_r[j] + 1'b1;
            end
        end
        if (!sys_rst_i && (touch_i || fill_i))
            age_r[use_idx] <= {IDX_W{1'b0}};
        if (!sys_rst_i && fill_i) begin
            valid_r[use_idx]  <= 1'b1;
            evalid_r[use_idx] <= fill_valid_i;
            tag_r[use_idx]    <= fill_tag_i;
            data_r[use_idx]   <= fill_data_i;
        end
    end
endmodule // aptlb_cache

// ===== design/aptlb_ctrl.v
// control register and translation flow for the aperture tlb
// What this block does
// - enable low flushes all cache entries
// - disabled: translations bypass the cache
// - disabled: aperture requests fetch table entry
// - disabled: valid fetched entries not cached
// - disabled: invalid fetched entries replace lru
// - enabled: normal lookup, fill, replacement
// - enable may change during an access
// - enable change waits for write-buffer flush
// - override makes rate field read 001
// - override forces 1x or 4x rate
// - rate code 001 means 1x or 4x
// limits: one translation in flight, and a request while busy is
// dropped; a write arriving while an enable change pends is dropped
// without completion, so software must wait for done before the next
// write
`timescale 1ns/1ps
`include "aptlb_map.vh"
module aptlb_ctrl #(
    parameter ENTRIES = 8,
    parameter IDX_W   = 3,
    parameter TAG_W   = 20,
    parameter DATA_W  = 32
) (
    input  wire              ref_clk_i,
    input  wire              sys_rst_i,
    input  wire              cfg_wr_i,
    input  wire              cfg_rd_i,
    input  wire [7:0]        cfg_addr_i,
    input  wire [3:0]        cfg_be_i,
    input  wire [31:0]       cfg_wdata_i,
    output reg  [31:0]       cfg_rdata_o,
    output reg               cfg_done_o,
    input  wire              wb_dirty_i,
    output reg               wb_flush_o,
    input  wire [2:0]        rate_true_i,
    output reg  [2:0]        rate_read_o,
    output reg               rate_forced_o,
    input  wire              xl_req_i,
    input  wire              xl_aperture_i,
    input  wire [TAG_W-1:0]  xl_tag_i,
    output reg               xl_done_o,
    output reg  [DATA_W-1:0] xl_entry_o,
    output reg               xl_bypass_o,
    output reg               mem_req_o,
    output reg  [TAG_W-1:0]  mem_tag_o,
    input  wire              mem_ack_i,
    input  wire [DATA_W-1:0] mem_data_i,
    input  wire              mem_valid_i
);
    localparam S_IDLE  = 2'h0;
    localparam S_FETCH = 2'h1;
    localparam S_WAIT  = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // control register and configuration write path
    reg              en_r;
    reg              ovr_r;
    reg              wpend_r;
    reg              wen_r;
    reg              wovr_r;
    wire             hit_ctrl;
    wire             wr_take;

    assign hit_ctrl = (cfg_addr_i == `APTLB_CTRL_OFFSET);
    assign wr_take  = cfg_wr_i && hit_ctrl && !wpend_r && cfg_be_i[0];

    // read image of the register: only the two live bits are stored
    reg  [31:0]      rdata_nxt;
    wire [2:0]       rate_nxt;

    always @* begin
        rdata_nxt = 32'h0;
        if (hit_ctrl) begin
            rdata_nxt[`APTLB_EN_BIT]  = en_r;
            rdata_nxt[`APTLB_OVR_BIT] = ovr_r;
        end
    end

    // forced code reads as 1x on older signalling, 4x on newer
    assign rate_nxt = ovr_r ? `APTLB_RATE_FORCED : rate_true_i;

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            en_r          <= 1'b0;
            ovr_r         <= 1'b0;
            wpend_r       <= 1'b0;
            wen_r         <= 1'b0;
            wovr_r        <= 1'b0;
            cfg_done_o    <= 1'b0;
            cfg_rdata_o   <= `APTLB_CTRL_RESET;
            wb_flush_o    <= 1'b0;
            rate_read_o   <= 3'h0;
            rate_forced_o <= 1'b0;
        end else begin
            // write completion is a one-cycle pulse
            cfg_done_o <= 1'b0;
            if (cfg_wr_i && !wpend_r && !(hit_ctrl && cfg_be_i[0])) begin
                cfg_done_o <= 1'b1;
            end else if (wr_take) begin
                wen_r  <= cfg_wdata_i[`APTLB_EN_BIT];
                wovr_r <= cfg_wdata_i[`APTLB_OVR_BIT];
                // old enable stays in force until the write buffer drains,
                // so a table edit never races a dirty table entry
                if (cfg_wdata_i[`APTLB_EN_BIT] != en_r) begin
                    wpend_r    <= 1'b1;
                    wb_flush_o <= 1'b1;
                end else begin
                    // override alone takes effect at once
                    ovr_r      <= cfg_wdata_i[`APTLB_OVR_BIT];
                    cfg_done_o <= 1'b1;
                end
            end else if (wpend_r && !wb_dirty_i) begin
                en_r       <= wen_r;
                ovr_r      <= wovr_r;
                wpend_r    <= 1'b0;
                wb_flush_o <= 1'b0;
                cfg_done_o <= 1'b1;
            end
            if (cfg_rd_i)
                cfg_rdata_o <= rdata_nxt;
            rate_forced_o <= ovr_r;
            rate_read_o   <= rate_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // translation sequencing
    reg  [1:0]        st_r;
    reg  [1:0]        st_nxt;
    wire              c_hit;
    wire [DATA_W-1:0] c_data;
    reg               touch;
    reg               fill;

    // an aperture request is only taken while the sequencer is idle
    function xl_start;
        input [1:0] state;
        input       req;
        input       aperture;
        begin
            xl_start = (state == S_IDLE) && req && aperture;
        end
    endfunction

    // flush is a level: entries are cleared each cycle the cache is off and no fill is written
    aptlb_cache #(
        .ENTRIES (ENTRIES),
        .IDX_W   (IDX_W),
        .TAG_W   (TAG_W),
        .DATA_W  (DATA_W)
    ) aptlb_cache_inst (
        .ref_clk_i    (ref_clk_i),
        .sys_rst_i    (sys_rst_i),
        .flush_i      (!en_r),
        .look_tag_i   (xl_tag_i),
        .hit_o        (c_hit),
        .hit_data_o   (c_data),
        .touch_i      (touch),
        .fill_i       (fill),
        .fill_tag_i   (mem_tag_o),
        .fill_data_i  (mem_data_i),
        .fill_valid_i (mem_valid_i)
    );

    always @* begin
        st_nxt = st_r;
        touch  = 1'b0;
        fill   = 1'b0;
        case (st_r)
            S_IDLE: begin
                if (xl_start(st_r, xl_req_i, xl_aperture_i)) begin
                    if (en_r && c_hit)
                        touch = 1'b1;
                    else
                        st_nxt = S_FETCH;
                end
            end
            S_FETCH: st_nxt = S_WAIT;
            S_WAIT: begin
                if (mem_ack_i) begin
                    // en_r sampled at fill time so a mid-access change is safe
                    fill   = en_r || !mem_valid_i;
                    st_nxt = S_IDLE;
                end
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            st_r        <= S_IDLE;
            xl_done_o   <= 1'b0;
            xl_entry_o  <= {DATA_W{1'b0}};
            xl_bypass_o <= 1'b0;
            mem_req_o   <= 1'b0;
            mem_tag_o   <= {TAG_W{1'b0}};
        end else begin
            st_r      <= st_nxt;
            xl_done_o <= 1'b0;
            // fetch request stands until the table answers
            mem_req_o <= (st_nxt == S_FETCH) || (st_nxt == S_WAIT);
            if (xl_start(st_r, xl_req_i, xl_aperture_i)) begin
                mem_tag_o   <= xl_tag_i;
                // bypass flag shows the enable in force at take time
                xl_bypass_o <= !en_r;
                if (touch) begin
                    xl_done_o  <= 1'b1;
                    xl_entry_o <= c_data;
                end
            end
            if (st_r == S_WAIT && mem_ack_i) begin
                xl_done_o  <= 1'b1;
                xl_entry_o <= mem_data_i;
            end
        end
    end
endmodule // aptlb_ctrl

// ===== verification/aptlb_props.sv
// assertion checker on the aperture tlb control ports
`timescale 1ns/1ps
module aptlb_props (
    input wire        ref_clk_i,
    input wire        sys_rst_i,
    input wire [31:0] cfg_rdata_o,
    input wire        cfg_done_o,
    input wire        wb_dirty_i,
    input wire        wb_flush_o,
    input wire [2:0]  rate_read_o,
    input wire        rate_forced_o,
    input wire        xl_done_o,
    input wire [31:0] xl_entry_o,
    input wire        mem_req_o,
    input wire        mem_ack_i,
    input wire [31:0] mem_data_i
);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (sys_rst_i);
a_rate_forced: assert property (rate_forced_o && $past(rate_forced_o)
    |-> rate_read_o == 3'h1) else $error("rate not forced");
a_flush_holds: assert property (wb_flush_o && wb_dirty_i
    |=> wb_flush_o && !cfg_done_o) else $error("done before flush");
a_flush_ends: assert property (wb_flush_o && !wb_dirty_i
    |=> cfg_done_o && !wb_flush_o) else $error("write not done");
a_fetch_done: assert property (mem_req_o && mem_ack_i
    |=> xl_done_o && !mem_req_o) else $error("fetch not closed");
a_entry_mem: assert property (mem_req_o && mem_ack_i
    |=> xl_entry_o == $past(mem_data_i)) else $error("entry wrong");
a_no_early: assert property (mem_req_o |-> !xl_done_o)
    else $error("done during fetch");
a_resv_zero: assert property (cfg_rdata_o[31:8] == 24'h0
    && cfg_rdata_o[6:1] == 6'h0) else $error("reserved set");
a_idle_start: assert property ($fell(sys_rst_i) |-> !cfg_done_o
    && !xl_done_o && !mem_req_o) else $error("busy after reset");
endmodule // aptlb_props
bind aptlb_ctrl aptlb_props aptlb_props_inst (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_done_o(cfg_done_o), .wb_dirty_i(wb_dirty_i),
    .wb_flush_o(wb_flush_o), .rate_read_o(rate_read_o),
    .rate_forced_o(rate_forced_o), .xl_done_o(xl_done_o),
    .xl_entry_o(xl_entry_o), .mem_req_o(mem_req_o),
    .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i));

// ===== verification/aptlb_mem_model.sv
// translation table memory answering table fetches
`timescale 1ns/1ps
module aptlb_mem_model (
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    input  wire [3:0]  lat_i,
    input  wire        valid_i,
    input  wire        req_i,
    input  wire [19:0] tag_i,
    output reg         ack_o,
    output reg  [31:0] data_o,
    output reg         valid_o
);
    reg [3:0] wait_r;
    always @(posedge ref_clk_i) begin
        ack_o <= 1'b0;
        data_o <= ~data_o;  // no stale entry off the ack
        valid_o <= ~valid_o;
        if (sys_rst_i || !req_i) begin
            wait_r <= sys_rst_i ? 4'hf : 4'h0;
            data_o <= 32'h5a5a5a5a;
            valid_o <= 1'b0;
        end else if (wait_r == lat_i) begin
            ack_o <= 1'b1;
            data_o <= {tag_i, 11'h0, valid_i};
            valid_o <= valid_i;
            wait_r <= 4'hf;
        end else if (wait_r != 4'hf) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule // aptlb_mem_model

// ===== verification/aperture_tlb_control_test.sv
// self-checking bench for the aperture tlb control
`timescale 1ns/1ps
module aperture_tlb_control_test;
    reg         clk, rst, wr, rd, dirty, req, ap, vld;
    reg  [7:0]  addr;
    reg  [3:0]  be, lat;
    reg  [31:0] wdata, got;
    reg  [2:0]  rtrue;
    reg  [19:0] tag;
    wire [31:0] rdata, entry, mdata;
    wire [19:0] mtag;
    wire [2:0]  rread;
    wire        done, flush, forced, xdone, byp, mreq, mack, mvld;
    integer     failures = 0, total_checks = 0, fetches = 0, cyc = 0, n;
    aptlb_ctrl aptlb_ctrl_inst (.ref_clk_i(clk), .sys_rst_i(rst),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .cfg_done_o(done),
        .wb_dirty_i(dirty), .wb_flush_o(flush), .rate_true_i(rtrue),
        .rate_read_o(rread), .rate_forced_o(forced), .xl_req_i(req),
        .xl_aperture_i(ap), .xl_tag_i(tag), .xl_done_o(xdone),
        .xl_entry_o(entry), .xl_bypass_o(byp), .mem_req_o(mreq),
        .mem_tag_o(mtag), .mem_ack_i(mack), .mem_data_i(mdata),
        .mem_valid_i(mvld));
    aptlb_mem_model aptlb_mem_model_inst (.ref_clk_i(clk), .sys_rst_i(rst),
        .lat_i(lat), .valid_i(vld), .req_i(mreq), .tag_i(mtag),
        .ack_o(mack), .data_o(mdata), .valid_o(mvld));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc = cyc + 1;
        fetches = fetches + mack;
        if (cyc == 3000) begin
            failures = failures + 1;
            print_verdict;
        end
    end
    task chk(input [8*12:1] what, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task step;
        begin
            @(posedge clk);
            #1;
        end
    endtask
    task wait_for(input integer sel);
        begin
            n = 0;
            while ((sel ? xdone : done) !== 1'b1 && n < 40) begin
                step;
                n = n + 1;
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [3:0] b, input [31:0] d);
        begin
            {addr, be, wdata, wr} = {a, b, d, 1'b1};
            step;
            wr = 1'b0;
            wait_for(0);
            chk("wr done", done, 1);
            step;
        end
    endtask
    task rd_reg;
        begin
            {addr, be, rd} = {8'hb0, 4'hf, 1'b1};
            step;
            rd = 1'b0;
            step;
            got = rdata;
        end
    endtask
    task xl(input [19:0] t, input [31:0] fexp, input b);
        integer f0;
        begin
            f0 = fetches;
            {tag, ap, req} = {t, 2'b11};
            step;
            req = 1'b0;
            wait_for(1);
            chk("xl done", xdone, 1);
            chk("bypass", byp, b);
            chk("entry", entry, {t, 11'h0, vld});
            chk("fetches", fetches - f0, fexp);
            step;
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d failures %0d", total_checks, failures);
            if (failures == 0 && total_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        {rst, wr, rd, dirty, req, ap, vld} = 7'h40;
        {addr, be, wdata, rtrue, tag, lat} = 71'h0;
        repeat (16) step;
        rst = 1'b0;
        rd_reg;
        chk("ctrl reset", got, 32'h0);
        {lat, vld} = 5'h5;
        xl(20'h00123, 1, 1);
        xl(20'h00123, 1, 1);
        vld = 1'b0;
        xl(20'h00456, 1, 1);
        $display("test bypass done");
        dirty = 1'b1;
        // dirty lines held two cycles past the take
        fork
            wr_reg(8'hb0, 4'hf, 32'hffffffff);
            begin
                repeat (3) step;
                dirty = 1'b0;
            end
        join
        chk("flush wait", n, 3);
        rd_reg;
        chk("ctrl ones", got, 32'h81);
        rtrue = 3'h4;
        repeat (2) step;
        chk("rate forced", rread, 3'h1);
        chk("forced", forced, 1);
        {lat, vld} = 5'h1;
        xl(20'h00789, 1, 0);
        xl(20'h00789, 0, 0);
        wr_reg(8'h00, 4'hf, 32'h0);
        wr_reg(8'hb0, 4'he, 32'h0);
        rd_reg;
        chk("ctrl kept", got, 32'h81);
        wr_reg(8'hb0, 4'hf, 32'h0);
        repeat (2) step;
        chk("rate true", rread, 3'h4);
        xl(20'h00789, 1, 1);
        $display("test enable done");
        print_verdict;
    end
endmodule // aperture_tlb_control_test
